//--- verilog/rfs_path_select.sv
// rfs_path_select: register bank and routing of the reader's transmit and
// receive paths: antenna driver source, aux output pin, contactless uart
// input, receiver guard timer, decoder thresholds, i/q choice, pll setting.
// assumes all inputs synchronous to sys_clk, bitClockTick one cycle wide.
`timescale 1ns/100ps

module rfs_path_select
	import rfs_pkg::*;
#(
	parameter int AMP_W = 8
)
(
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire rfsRegReq_t        regReq,
	output logic [DATA_W-1:0]      rdData,
	output logic                   rdValid,
	input  wire logic              millerEnvelope,
	input  wire logic              txSerialData,
	input  wire logic              rxDecodedData,
	input  wire logic              auxEnvelopeInput,
	input  wire logic              auxInputPin,
	input  wire logic              analogRxSignal,
	input  wire logic [7:0]        testBus,
	input  wire logic [2:0]        testBusBitSelect,
	input  wire logic [1:0]        driverInvertOn,
	input  wire logic [1:0]        driverInvertOff,
	input  wire logic [1:0]        driverEnable,
	input  wire logic              softPowerDown,
	output rfsPin_t [1:0]          antennaDriver,
	output rfsPin_t                auxOutputPin,
	output logic                   uartRxInput,
	input  wire logic              txDone,
	input  wire logic              bitClockTick,
	input  wire logic              rfFieldOn,
	input  wire logic              cmdIsReceive,
	output logic                   rxGuardActive,
	input  wire logic [3:0]        signalStrength,
	input  wire logic [AMP_W-1:0]  strongHalfAmp,
	input  wire logic [AMP_W-1:0]  weakHalfAmp,
	input  wire logic              halfBitValid,
	output logic                   bitAccepted,
	output logic                   bitCollision,
	input  wire logic [AMP_W-1:0]  iChannelAmp,
	input  wire logic [AMP_W-1:0]  qChannelAmp,
	input  wire logic              commActive,
	output logic                   useQChannel,
	input  wire logic              rxDataPhase,
	output logic [1:0]             pllTimeConstant,
	output logic                   pllFrozen
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (AMP_W < 2 || AMP_W > 16)
	begin : g_bad_amp
		$error("AMP_W must lie between 2 and 16");
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [7:0]             txSel_q;
	logic [7:0]             rxSel_q;
	logic [7:0]             thresh_q;
	logic [7:0]             demod_q;
	logic [DATA_W-1:0]      rdData_q;
	logic                   rdValid_q;
	logic [DATA_W-1:0]      rdMux;

	// only writable bits are stored, so reserved bits can never read one
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			txSel_q  <= RST_TX_SEL;
			rxSel_q  <= RST_RX_SEL;
			thresh_q <= RST_THRESH;
			demod_q  <= RST_DEMOD;
		end
		else if (regReq.wrStrobe)
		begin
			unique case (regReq.addr)
				OFF_TX_SEL: txSel_q  <= regReq.wrData & MSK_TX_SEL;
				OFF_RX_SEL: rxSel_q  <= regReq.wrData & MSK_RX_SEL;
				OFF_THRESH: thresh_q <= regReq.wrData & MSK_THRESH;
				OFF_DEMOD:  demod_q  <= regReq.wrData & MSK_DEMOD;
				default:    ;
			endcase
		end
	end

	// read decode; unmapped and reserved offsets answer zero
	always_comb
	begin
		unique case (regReq.addr)
			OFF_TX_SEL: rdMux = txSel_q;
			OFF_RX_SEL: rdMux = rxSel_q;
			OFF_THRESH: rdMux = thresh_q;
			OFF_DEMOD:  rdMux = demod_q;
			default:    rdMux = READ_ZERO;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdData_q  <= READ_ZERO;
			rdValid_q <= 1'b0;
		end
		else
		begin
			rdData_q  <= regReq.rdStrobe ? rdMux : READ_ZERO;
			rdValid_q <= regReq.rdStrobe;
		end
	end

	assign rdData  = rdData_q;
	assign rdValid = rdValid_q;

	// ----------------------------------------------------------------
	// field extraction
	// ----------------------------------------------------------------
	rfsDrvSrc_t             drvSrc;
	logic [3:0]             auxSrc;
	rfsUartSrc_t            uartSrc;
	logic [GUARD_W-1:0]     rxGuardBits;
	logic [3:0]             minDecodeLevel;
	logic [2:0]             collisionLevel;
	logic [1:0]             iqChannelMode;
	logic                   iqChannelFix;
	logic [1:0]             pllRxTimeConstant;
	logic [1:0]             pllBurstTimeConstant;

	assign drvSrc               = rfsDrvSrc_t'(txSel_q[DRV_SRC_LSB +: 2]);
	assign auxSrc               = txSel_q[AUX_SRC_LSB +: 4];
	assign uartSrc              = rfsUartSrc_t'(rxSel_q[UART_SRC_LSB +: 2]);
	assign rxGuardBits          = rxSel_q[GUARD_LSB +: GUARD_W];
	assign minDecodeLevel       = thresh_q[MIN_LVL_LSB +: 4];
	assign collisionLevel       = thresh_q[COLL_LSB +: 3];
	assign iqChannelMode        = demod_q[IQ_MODE_LSB +: 2];
	assign iqChannelFix         = demod_q[IQ_FIX_BIT];
	assign pllRxTimeConstant    = demod_q[TAU_RCV_LSB +: 2];
	assign pllBurstTimeConstant = demod_q[TAU_SYNC_LSB +: 2];

	// ----------------------------------------------------------------
	// antenna drivers
	// ----------------------------------------------------------------
	logic                   drvRaw;
	logic [1:0]             driverOn;

	// shared envelope choice for both drivers
	always_comb
	begin
		unique case (drvSrc)
			DRV_TRISTATE: drvRaw = 1'b0;
			DRV_MILLER:   drvRaw = millerEnvelope;
			DRV_AUX_ENV:  drvRaw = auxEnvelopeInput;
			DRV_HIGH:     drvRaw = 1'b1;
		endcase
	end

	// soft power-down counts as driver off but keeps the pin driven
	// unless the source is the tristate code
	for (genvar g = 0; g < 2; g++)
	begin : g_driver
		assign driverOn[g] = driverEnable[g] & ~softPowerDown;

		always_ff @(posedge sys_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				antennaDriver[g] <= '{level: 1'b0, outEnN: 1'b1};
			end
			else
			begin
				antennaDriver[g].outEnN <= (drvSrc == DRV_TRISTATE);
				antennaDriver[g].level  <= driverOn[g] ? (drvRaw ^ driverInvertOn[g])
				                                       : driverInvertOff[g];
			end
		end
	end

	// ----------------------------------------------------------------
	// aux output pin
	// ----------------------------------------------------------------
	// reserved codes float the pin so a bad setting cannot fight a load
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			auxOutputPin <= '{level: 1'b0, outEnN: 1'b1};
		end
		else
		begin
			auxOutputPin.outEnN <= 1'b0;
			unique case (auxSrc)
				AUX_TRISTATE:
				begin
					auxOutputPin.level  <= 1'b0;
					auxOutputPin.outEnN <= 1'b1;
				end
				AUX_LOW:      auxOutputPin.level <= 1'b0;
				AUX_HIGH:     auxOutputPin.level <= 1'b1;
				AUX_TEST_BUS: auxOutputPin.level <= testBus[testBusBitSelect];
				AUX_MILLER:   auxOutputPin.level <= millerEnvelope;
				AUX_TX_DATA:  auxOutputPin.level <= txSerialData;
				AUX_RX_DATA:  auxOutputPin.level <= rxDecodedData;
				default:
				begin
					auxOutputPin.level  <= 1'b0;
					auxOutputPin.outEnN <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receiver guard timer
	// ----------------------------------------------------------------
	logic [GUARD_W-1:0]     guardCount_q;
	logic                   rfFieldPrev_q;
	logic                   guardStart;

	// the plain receive command never arms the guard
	assign guardStart = (txDone & ~cmdIsReceive) | (rfFieldOn & ~rfFieldPrev_q);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rfFieldPrev_q <= 1'b0;
		end
		else
		begin
			rfFieldPrev_q <= rfFieldOn;
		end
	end

	// counts bit clocks down to zero; a new start reloads
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			guardCount_q <= '0;
		end
		else if (guardStart)
		begin
			guardCount_q <= rxGuardBits;
		end
		else if (bitClockTick && guardCount_q != '0)
		begin
			guardCount_q <= guardCount_q - 1'b1;
		end
	end

	assign rxGuardActive = (guardCount_q != '0);

	// ----------------------------------------------------------------
	// contactless uart input
	// ----------------------------------------------------------------
	logic                   contactless_uart_source;
	logic                   uartRxInput_q;

	always_comb
	begin
		unique case (uartSrc)
			UART_LOW:     contactless_uart_source = 1'b0;
			UART_AUX_MAN: contactless_uart_source = auxInputPin;
			UART_ANALOG:  contactless_uart_source = analogRxSignal;
			UART_AUX_NRZ: contactless_uart_source = auxInputPin;
		endcase
	end

	// nrz path is passed as is; the bit rate limit is software's to keep
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			uartRxInput_q <= 1'b0;
		end
		else
		begin
			uartRxInput_q <= (rxGuardActive && !cmdIsReceive) ? 1'b0 : contactless_uart_source;
		end
	end

	assign uartRxInput = uartRxInput_q;

	// ----------------------------------------------------------------
	// bit decoder thresholds
	// ----------------------------------------------------------------
	logic [AMP_W+COLL_FRAC_W-1:0] weakScaled;
	logic [AMP_W+COLL_FRAC_W-1:0] strongScaled;
	logic                         levelOk;

	// collision level is in eighths of the stronger half-bit
	assign weakScaled   = {weakHalfAmp, 3'h0};
	assign strongScaled = {3'h0, strongHalfAmp} * {{AMP_W{1'b0}}, collisionLevel};
	assign levelOk      = (signalStrength >= minDecodeLevel);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bitAccepted  <= 1'b0;
			bitCollision <= 1'b0;
		end
		else
		begin
			bitAccepted  <= halfBitValid && levelOk;
			bitCollision <= halfBitValid && levelOk && (weakScaled >= strongScaled);
		end
	end

	// ----------------------------------------------------------------
	// i/q channel choice
	// ----------------------------------------------------------------
	logic                   qStronger;
	logic                   commPrev_q;
	logic                   frozenQ_q;
	logic                   frozenSel;

	assign qStronger = (qChannelAmp > iChannelAmp);
	assign frozenSel = (commActive && !commPrev_q) ? qStronger : frozenQ_q;

	// the choice is taken in the first cycle of a communication
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			commPrev_q <= 1'b0;
			frozenQ_q  <= 1'b0;
		end
		else
		begin
			commPrev_q <= commActive;
			frozenQ_q  <= frozenSel;
		end
	end

	// reserved modes with the fix bit low behave as plain stronger choice
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			useQChannel <= 1'b0;
		end
		else if (iqChannelFix)
		begin
			useQChannel <= iqChannelMode[0];
		end
		else if (iqChannelMode == IQ_FREEZE && commActive)
		begin
			useQChannel <= frozenSel;
		end
		else
		begin
			useQChannel <= qStronger;
		end
	end

	// ----------------------------------------------------------------
	// pll time constant
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pllTimeConstant <= 2'h0;
			pllFrozen       <= 1'b0;
		end
		else
		begin
			pllTimeConstant <= rxDataPhase ? pllRxTimeConstant : pllBurstTimeConstant;
			pllFrozen       <= rxDataPhase && (pllRxTimeConstant == 2'h0);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_guard_armed;
		guardStart && rxGuardBits != '0;
	endsequence

	sequence s_guard_held;
		rxGuardActive && !cmdIsReceive;
	endsequence

	// settings must already have stood a cycle, else the held choice may
	// still be the one made under the previous mode
	sequence s_freeze_held;
		!iqChannelFix && iqChannelMode == IQ_FREEZE && commActive && commPrev_q
			&& $stable(demod_q);
	endsequence

	a_drv_tristate: assert property (
		drvSrc == DRV_TRISTATE |=> antennaDriver[0].outEnN && antennaDriver[1].outEnN)
		else $error("drivers not tristate for source 00");
	a_drv_miller: assert property (
		drvSrc == DRV_MILLER && driverOn[0] |=>
			antennaDriver[0].level == ($past(millerEnvelope) ^ $past(driverInvertOn[0])))
		else $error("driver 1 does not follow miller envelope");
	a_drv_high: assert property (
		drvSrc == DRV_HIGH && driverOn[1] |=>
			!antennaDriver[1].outEnN && antennaDriver[1].level == !$past(driverInvertOn[1]))
		else $error("driver 2 high level wrong");
	a_drv_off_inv: assert property (
		!driverOn[0] |=> antennaDriver[0].level == $past(driverInvertOff[0]))
		else $error("disabled driver level ignores off inversion");
	a_aux_levels: assert property (
		auxSrc == AUX_HIGH |=> auxOutputPin.level && !auxOutputPin.outEnN)
		else $error("aux pin not high for 0010");
	a_aux_testbus: assert property (
		auxSrc == AUX_TEST_BUS |=> auxOutputPin.level == $past(testBus[testBusBitSelect]))
		else $error("aux pin not on selected test bus line");
	a_aux_reserved: assert property (
		auxSrc == 4'h6 || auxSrc[3] |=> auxOutputPin.outEnN)
		else $error("aux pin driven for reserved code");
	a_uart_analog: assert property (
		uartSrc == UART_ANALOG && !rxGuardActive |=> uartRxInput == $past(analogRxSignal))
		else $error("uart input not on analog receiver");
	a_guard_start: assert property (
		s_guard_armed |=> rxGuardActive [*2] or (rxGuardActive ##1 1'b1))
		else $error("guard not active after start");
	a_guard_ignore: assert property (
		s_guard_held |=> !uartRxInput)
		else $error("receive input passed during guard time");
	a_field_on: assert property (
		rfFieldOn && !rfFieldPrev_q && rxGuardBits != '0 |=> rxGuardActive)
		else $error("guard did not start at field on");
	a_recv_noguard: assert property (
		cmdIsReceive && uartSrc == UART_ANALOG |=> uartRxInput == $past(analogRxSignal))
		else $error("receive command delayed by guard");
	a_min_level: assert property (
		signalStrength < minDecodeLevel |=> !bitAccepted && !bitCollision)
		else $error("weak signal evaluated");
	a_iq_fixed: assert property (
		iqChannelFix |=> useQChannel == $past(iqChannelMode[0]))
		else $error("fixed channel not honoured");
	a_iq_freeze: assert property (
		s_freeze_held ##1 $stable(demod_q) && commActive |-> $stable(useQChannel))
		else $error("frozen channel changed during communication");
	a_pll_freeze: assert property (
		rxDataPhase && pllRxTimeConstant == 2'h0 |=> pllFrozen && pllTimeConstant == 2'h0)
		else $error("pll not frozen for receive constant 00");
	a_pll_burst: assert property (
		!rxDataPhase |=> !pllFrozen && pllTimeConstant == $past(pllBurstTimeConstant))
		else $error("burst time constant not applied");
	a_rsvd_read: assert property (
		regReq.rdStrobe && regReq.addr == OFF_RSVD_1A |=> rdValid && rdData == READ_ZERO)
		else $error("reserved register read not zero");

endmodule : rfs_path_select

//--- verilog/rfs_pkg.sv
// rfs_pkg: register map, field layout, reset values and source codes
// of the transmit/receive path select block.
// assumes byte-wide registers on a plain strobe port with a 6-bit address.
package rfs_pkg;

	// ----------------------------------------------------------------
	// bus geometry and register offsets
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 6;
	localparam int          DATA_W        = 8;
	localparam logic [5:0]  OFF_TX_SEL    = 6'h16;
	localparam logic [5:0]  OFF_RX_SEL    = 6'h17;
	localparam logic [5:0]  OFF_THRESH    = 6'h18;
	localparam logic [5:0]  OFF_DEMOD     = 6'h19;
	localparam logic [5:0]  OFF_RSVD_1A   = 6'h1A;

	// ----------------------------------------------------------------
	// reset values and writable-bit masks (reserved bits stay zero)
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_TX_SEL    = 8'h10;
	localparam logic [7:0]  RST_RX_SEL    = 8'h84;
	localparam logic [7:0]  RST_THRESH    = 8'h84;
	localparam logic [7:0]  RST_DEMOD     = 8'h4D;
	localparam logic [7:0]  MSK_TX_SEL    = 8'h3F;
	localparam logic [7:0]  MSK_RX_SEL    = 8'hFF;
	localparam logic [7:0]  MSK_THRESH    = 8'hF7;
	localparam logic [7:0]  MSK_DEMOD     = 8'hEF;
	localparam logic [7:0]  READ_ZERO     = 8'h00;

	// ----------------------------------------------------------------
	// field positions (lsb of each field) and field widths
	// ----------------------------------------------------------------
	localparam int          DRV_SRC_LSB   = 4;
	localparam int          AUX_SRC_LSB   = 0;
	localparam int          UART_SRC_LSB  = 6;
	localparam int          GUARD_LSB     = 0;
	localparam int          GUARD_W       = 6;
	localparam int          MIN_LVL_LSB   = 4;
	localparam int          COLL_LSB      = 0;
	localparam int          IQ_MODE_LSB   = 6;
	localparam int          IQ_FIX_BIT    = 5;
	localparam int          TAU_RCV_LSB   = 2;
	localparam int          TAU_SYNC_LSB  = 0;
	localparam int          COLL_FRAC_W   = 3;

	// ----------------------------------------------------------------
	// source codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DRV_TRISTATE = 2'b00,
		DRV_MILLER   = 2'b01,
		DRV_AUX_ENV  = 2'b10,
		DRV_HIGH     = 2'b11
	} rfsDrvSrc_t;

	typedef enum logic [3:0] {
		AUX_TRISTATE = 4'h0,
		AUX_LOW      = 4'h1,
		AUX_HIGH     = 4'h2,
		AUX_TEST_BUS = 4'h3,
		AUX_MILLER   = 4'h4,
		AUX_TX_DATA  = 4'h5,
		AUX_RX_DATA  = 4'h7
	} rfsAuxSrc_t;

	typedef enum logic [1:0] {
		UART_LOW     = 2'b00,
		UART_AUX_MAN = 2'b01,
		UART_ANALOG  = 2'b10,
		UART_AUX_NRZ = 2'b11
	} rfsUartSrc_t;

	typedef enum logic [1:0] {
		IQ_STRONGER  = 2'b00,
		IQ_FREEZE    = 2'b01
	} rfsIqMode_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic              wrStrobe;
		logic              rdStrobe;
	} rfsRegReq_t;

	typedef struct packed {
		logic level;
		logic outEnN;
	} rfsPin_t;

endpackage : rfs_pkg

//--- tb/rfs_front_end.sv
// rfs_front_end: behavioural model of the analog front end and aux input pins
// assumes the bench picks the line pattern; the lines follow it one clock later
`timescale 1ns/100ps

module rfs_front_end
	import rfs_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic [2:0] pattern,
	output logic            auxEnvelopeInput,
	output logic            auxInputPin,
	output logic            analogRxSignal
);

	// ----------------------------------------------------------------
	// line drivers
	// ----------------------------------------------------------------
	// registered, so the lines move only on a clock edge, never between edges
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			{auxEnvelopeInput, auxInputPin, analogRxSignal} <= 3'h0;
		else
			{auxEnvelopeInput, auxInputPin, analogRxSignal} <= pattern;
	end

endmodule : rfs_front_end

//--- tb/tb.sv
// tb: self-checking bench for rfs_path_select and its front-end model
// assumes one 10 MHz clock; register reads are checked off a queue
`timescale 1ns/100ps

module tb import rfs_pkg::*; ();

	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic          sys_clk, rstn, rdValid, uartRxInput, rxGuardActive, bitAccepted;
	logic          bitCollision, useQChannel, pllFrozen, millerEnvelope, txSerialData;
	logic          rxDecodedData, auxEnvelopeInput, auxInputPin, analogRxSignal;
	logic          softPowerDown, txDone, bitClockTick, rfFieldOn, cmdIsReceive;
	logic          halfBitValid, commActive, rxDataPhase, src;
	logic [1:0]    driverInvertOn, driverInvertOff, driverEnable, pllTimeConstant, ax;
	logic [2:0]    testBusBitSelect, pattern;
	logic [3:0]    signalStrength;
	logic [7:0]    rdData, testBus, strongHalfAmp, weakHalfAmp, iChannelAmp, qChannelAmp;
	logic [15:0]   lf;
	rfsRegReq_t    regReq;
	rfsPin_t [1:0] antennaDriver;
	rfsPin_t       auxOutputPin;
	logic [7:0]    expQ[$];
	int            failures, nTests, k, i;
	logic [5:0]    offs[6] = '{6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h3F};
	logic [7:0]    rstv[6] = '{8'h10, 8'h84, 8'h84, 8'h4D, 8'h00, 8'h00};
	logic [7:0]    mskv[6] = '{8'h3F, 8'hFF, 8'hF7, 8'hEF, 8'h00, 8'h00};
	// strength, strong, weak, accepted, collision
	logic [21:0]   decTab[4] = '{22'h1A0A00, 22'h2140A3, 22'h21409E, 22'h3D4143};
	// demod byte, i stronger, data phase, q used, time constant, frozen
	logic [13:0]   iqTab[4] = '{14'h0811, 14'h186A, 14'h039E, 14'h03A4};

	rfs_path_select u_rfs_path_select (.sys_clk, .rstn, .regReq, .rdData, .rdValid,
		.millerEnvelope, .txSerialData, .rxDecodedData, .auxEnvelopeInput, .auxInputPin,
		.analogRxSignal, .testBus, .testBusBitSelect, .driverInvertOn, .driverInvertOff,
		.driverEnable, .softPowerDown, .antennaDriver, .auxOutputPin, .uartRxInput, .txDone,
		.bitClockTick, .rfFieldOn, .cmdIsReceive, .rxGuardActive, .signalStrength,
		.strongHalfAmp, .weakHalfAmp, .halfBitValid, .bitAccepted, .bitCollision,
		.iChannelAmp, .qChannelAmp, .commActive, .useQChannel, .rxDataPhase,
		.pllTimeConstant, .pllFrozen);
	rfs_front_end u_rfs_front_end (.sys_clk, .rstn, .pattern, .auxEnvelopeInput,
		.auxInputPin, .analogRxSignal);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always #50 sys_clk = ~sys_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task end_sim;
		if (failures == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// strobe stays up so ops may run back to back; a read notes its result
	task op(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regReq <= '{addr: a, wrData: d, wrStrobe: w, rdStrobe: ~w};
		if (!w)
			expQ.push_back(d);
	endtask : op

	task settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : settle

	// one extra cycle covers the front-end model's register
	task stim;
		@(posedge sys_clk);
		regReq <= '0;
		lf = lfsr(lf);
		{millerEnvelope, txSerialData, rxDecodedData, softPowerDown, driverInvertOn,
			driverInvertOff, driverEnable, pattern, testBusBitSelect} <= lf;
		lf = lfsr(lf);
		testBus <= lf[7:0];
		@(posedge sys_clk);
		settle;
	endtask : stim

	task tick(input logic exp);
		@(posedge sys_clk) bitClockTick <= 1'b1;
		@(posedge sys_clk) bitClockTick <= 1'b0;
		#1 chk(rxGuardActive, exp);
	endtask : tick

	// read results come one cycle after the strobe; the oldest note is theirs
	always @(posedge sys_clk)
		if (rdValid === 1'b1)
			chk(rdData, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);

	// hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		#2000000;
		failures++;
		end_sim;
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		{sys_clk, rstn, regReq, lf, failures, nTests} = '0;
		{millerEnvelope, txSerialData, rxDecodedData, softPowerDown, driverInvertOn} = '0;
		{driverInvertOff, driverEnable, pattern, testBusBitSelect, testBus, txDone} = '0;
		{bitClockTick, rfFieldOn, cmdIsReceive, signalStrength, strongHalfAmp} = '0;
		{weakHalfAmp, halfBitValid, iChannelAmp, qChannelAmp, commActive, rxDataPhase} = '0;
		lf = 16'h0B63;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		for (k = 0; k < 18; k++)
			op(k / 6 == 1, offs[k % 6], k < 6 ? rstv[k] : k < 12 ? 8'hFF : mskv[k % 6]);
		for (k = 0; k < 32; k++)
		begin
			op(1'b1, OFF_TX_SEL, {2'b00, k[1:0], k[3:0]});
			stim;
			src = k[1:0] == 2'b01 ? millerEnvelope : k[1] & (k[0] | auxEnvelopeInput);
			for (i = 0; i < 2; i++)
			begin
				chk(antennaDriver[i].outEnN, k[1:0] == 2'b00);
				if (k[1:0] != 2'b00)
					chk(antennaDriver[i].level, (driverEnable[i] & ~softPowerDown) ?
						src ^ driverInvertOn[i] : driverInvertOff[i]);
			end
			case (k[3:0])
				4'h1: ax = 2'b00;
				4'h2: ax = 2'b01;
				4'h3: ax = {1'b0, testBus[testBusBitSelect]};
				4'h4: ax = {1'b0, millerEnvelope};
				4'h5: ax = {1'b0, txSerialData};
				4'h7: ax = {1'b0, rxDecodedData};
				default: ax = 2'b10;
			endcase
			chk({auxOutputPin.outEnN, auxOutputPin.level & (k[3:0] != 4'h0)}, ax);
		end
		for (k = 0; k < 4; k++)
		begin
			op(1'b1, OFF_RX_SEL, {k[1:0], 6'h00});
			stim;
			chk(uartRxInput, k == 0 ? 1'b0 : k == 2 ? analogRxSignal : auxInputPin);
		end
		op(1'b1, OFF_RX_SEL, 8'h83);
		@(posedge sys_clk);
		{regReq, pattern, txDone} <= {{$bits(rfsRegReq_t){1'b0}}, 4'hF};
		@(posedge sys_clk);
		txDone <= 1'b0;
		#1 chk(rxGuardActive, 1'b1);
		settle;
		chk(uartRxInput, 1'b0);
		for (i = 0; i < 3; i++)
			tick(i < 2);
		settle;
		chk(uartRxInput, 1'b1);
		@(posedge sys_clk) {cmdIsReceive, txDone} <= 2'b11;
		@(posedge sys_clk) txDone <= 1'b0;
		#1 chk(rxGuardActive, 1'b0);
		@(posedge sys_clk) {cmdIsReceive, rfFieldOn} <= 2'b01;
		settle;
		chk(rxGuardActive, 1'b1);
		for (i = 0; i < 3; i++)
			tick(i < 2);
		op(1'b1, OFF_THRESH, 8'h84);
		for (k = 0; k < 4; k++)
		begin
			@(posedge sys_clk);
			regReq <= '0;
			{halfBitValid, signalStrength, strongHalfAmp, weakHalfAmp} <= {1'b1, decTab[k][21:2]};
			settle;
			chk({bitAccepted, bitCollision}, decTab[k][1:0]);
		end
		for (k = 0; k < 6; k++)
		begin
			op(1'b1, OFF_DEMOD, k < 4 ? iqTab[k][13:6] : 8'h40);
			@(posedge sys_clk);
			regReq <= '0;
			{commActive, rxDataPhase} <= {k == 4 || k == 5, k < 4 && iqTab[k][4]};
			{iChannelAmp, qChannelAmp} <= (k < 4 ? iqTab[k][5] : k == 5) ? 16'hC040 : 16'h40C0;
			settle;
			if (k < 4)
				chk({useQChannel, pllTimeConstant, pllFrozen}, iqTab[k][3:0]);
			else
				chk(useQChannel, 1'b1);
		end
		chk(8'(expQ.size()), 8'h00);
		end_sim;
	end

endmodule : tb
